/* File: hdl/psa_sram_access.sv */
// Function
// - High sleep request enters sleep, no accesses, contents kept.
// - Write data and parity captured into a data register each rising edge.
// - Read drives data of location addressed at the preceding edge.
// - Output enable low drives data pins; high holds them released.
// - Burst strap low selects linear, high interleaved; kept static outside.
// - All synchronous inputs and data outputs are registered on rising edge.
// - Two-bit wrapping counter latches burst start and steps under burst advance.
// - Global write writes all four lanes, overriding byte controls.
// - Read starts on a strobe, chip selected, no write; processor strobe needs primary select.
// - Read loads address; data leaves output register after next edge.
// - Outputs stay released in first cycle when emerging from deselect.
// - Deselect by chip selects and a strobe releases outputs at once.
// - Back-to-back single reads need no idle cycles.
// - Processor-strobe start loads address, ignoring write controls and advance.
// - Processor-strobe write takes two clocks; global write low writes all bytes.
// - Byte write enable with lane selects writes only chosen lanes.
// - Any detected write cycle releases outputs regardless of output enable.
// - Both strobes low acts on processor strobe only while primary select is low.
// - Low burst advance steps counter to next address in burst order.
// - Chip selects sampled only when a new external address loads.
// - Controller-strobe write completes in one clock with same-edge controls.
`timescale 1ns/1ps
module psa_sram_access
  import psa_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  input  wire logic                     sys_clk_in,
  input  wire logic                     rst_b_in,
  input  wire logic [AW-1:0]            addr_in,
  input  wire psa_pkg::psa_ctl_t        ctl_in,
  input  wire logic [psa_pkg::DATA_W-1:0] data_in,
  input  wire logic [psa_pkg::LANES-1:0]  parity_in,
  output logic      [psa_pkg::DATA_W-1:0] data_out,
  output logic      [psa_pkg::LANES-1:0]  parity_out,
  output logic                          data_oe_out,
  input  wire logic                     oe_n_in,
  input  wire logic                     sleep_request_in,
  input  wire logic                     burst_mode_in,
  output logic                          sleep_active_out
);
  import psa_pkg::*;

  // Input registers
  logic [AW-1:0]     addr_r;
  psa_ctl_t          ctl_r;
  logic [WORD_W-1:0] wdata_r;
  logic              sleep_r;
  logic              mode_r;

  // Control state
  psa_state_t        state_r;
  psa_state_t        state_nxt;
  logic              pend_processor_addr_strobe_n_r;
  logic              drive_r;
  logic              drive_nxt;
  logic [AW-1:0]     upper_r;
  logic [WORD_W-1:0] out_r;

  // Decode
  logic              sel_now;
  logic              processor_addr_strobe_n_act;
  logic              controller_addr_strobe_n_act;
  logic              load;
  logic              start;
  logic              desel;
  logic              cont;
  logic [LANES-1:0]  lane_req;
  logic              wr_req;
  logic              write_cyc;
  logic              read_cyc;
  logic              step;
  logic [LANES-1:0]  lane_we;
  logic [BURST_W-1:0] burst_lo;
  logic [AW-1:0]     acc_addr;
  logic [WORD_W-1:0] rdata;
  logic [WORD_W-1:0] word_in;

  // Pull-down on sleep and pull-up on mode are pad features, not modelled
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      ctl_r   <= CTL_IDLE;
      sleep_r <= 1'b0;
      mode_r  <= MODE_INTERLEAVED;
    end else begin
      ctl_r   <= ctl_in;
      sleep_r <= sleep_request_in;
      mode_r  <= burst_mode_in;
    end
  end

  for (genvar i = 0; i < LANES; i++) begin : g_pack
    assign word_in[i*LANE_W +: LANE_W] = {parity_in[i], data_in[i*BYTE_W +: BYTE_W]};
    assign data_out[i*BYTE_W +: BYTE_W] = out_r[i*LANE_W +: BYTE_W];
    assign parity_out[i] = out_r[i*LANE_W + BYTE_W];
  end

  // Address and data registers hold no control meaning, so they skip reset
  always_ff @(posedge sys_clk_in) begin
    addr_r  <= addr_in;
    wdata_r <= word_in;
  end

  assign sel_now  = !ctl_r.chip_select_primary_n && ctl_r.chip_select_high
                    && !ctl_r.chip_select_third_n;
  // Processor strobe counts only with primary select low, and it wins
  assign processor_addr_strobe_n_act = !ctl_r.processor_addr_strobe_n
                    && !ctl_r.chip_select_primary_n && !sleep_r;
  assign controller_addr_strobe_n_act = !ctl_r.controller_addr_strobe_n && !processor_addr_strobe_n_act && !sleep_r;
  assign load     = processor_addr_strobe_n_act || controller_addr_strobe_n_act;
  assign start    = load && sel_now;
  assign desel    = load && !sel_now;
  assign cont     = !load && !sleep_r && (state_r == ST_ACTIVE);

  assign lane_req = !ctl_r.global_write_n ? {LANES{1'b1}} :
                    (!ctl_r.byte_write_enable_n ? ~ctl_r.byte_lane_select_n
                                                : {LANES{1'b0}});
  assign wr_req   = |lane_req;

  // Processor-strobe start ignores write controls; its write lands next cycle
  assign write_cyc = (start && controller_addr_strobe_n_act && wr_req)
                     || (cont && wr_req);
  assign read_cyc  = (start && (processor_addr_strobe_n_act || !wr_req))
                     || (cont && !wr_req);
  assign lane_we   = write_cyc ? lane_req : {LANES{1'b0}};

  // Second cycle of a processor-strobe write stays on the loaded address
  assign step = cont && !ctl_r.burst_step_n
                && !(pend_processor_addr_strobe_n_r && wr_req);

  psa_burst_ctr u_burst (
    .sys_clk_in  (sys_clk_in),
    .rst_b_in    (rst_b_in),
    .load_in     (start),
    .start_in    (addr_r[BURST_W-1:0]),
    .step_in     (step),
    .mode_in     (mode_r),
    .addr_lo_out (burst_lo)
  );

  // Only the low bits come from the counter during a burst
  assign acc_addr = start ? addr_r
                          : {upper_r[AW-1:BURST_W], burst_lo};

  psa_mem #(
    .AW (AW)
  ) u_mem (
    .sys_clk_in (sys_clk_in),
    .addr_in    (acc_addr),
    .lane_we_in (lane_we),
    .wdata_in   (wdata_r),
    .rdata_out  (rdata)
  );

  always_comb begin
    state_nxt = state_r;
    if (sleep_r) begin
      state_nxt = ST_SLEEP;
    end else if (start) begin
      state_nxt = ST_ACTIVE;
    end else if (desel || state_r == ST_SLEEP) begin
      state_nxt = ST_DESEL;
    end
  end

  // Output register only becomes drivable after a read cycle; a read out of
  // deselect therefore shows nothing during its first cycle
  assign drive_nxt = read_cyc;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      state_r     <= ST_DESEL;
      pend_processor_addr_strobe_n_r <= PEND_RST;
      drive_r     <= DRIVE_RST;
    end else begin
      state_r     <= state_nxt;
      pend_processor_addr_strobe_n_r <= start && processor_addr_strobe_n_act;
      drive_r     <= drive_nxt;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (start) begin
      upper_r <= addr_r;
    end
    if (read_cyc) begin
      out_r <= rdata;
    end
  end

  // Output enable acts without the clock; writes and deselects override it
  assign data_oe_out = drive_r && !oe_n_in
                       && !write_cyc
                       && !desel
                       && (state_r != ST_SLEEP) && !sleep_r;

  assign sleep_active_out = (state_r == ST_SLEEP);

endmodule : psa_sram_access

/* File: hdl/psa_pkg.sv */
package psa_pkg;

  localparam int ADDR_W   = 18;
  localparam int LANES    = 4;
  localparam int BYTE_W   = 8;
  localparam int LANE_W   = BYTE_W + 1;
  localparam int DATA_W   = LANES * BYTE_W;
  localparam int WORD_W   = LANES * LANE_W;
  localparam int BURST_W  = 2;

  // Burst order strap levels
  localparam logic MODE_LINEAR      = 1'b0;
  localparam logic MODE_INTERLEAVED = 1'b1;

  // Values after reset
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic               DRIVE_RST = 1'b0;
  localparam logic               PEND_RST  = 1'b0;

  typedef enum logic [1:0] {
    ST_DESEL  = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_SLEEP  = 2'b10
  } psa_state_t;

  // Synchronous controls, all active levels as on the pins
  typedef struct packed {
    logic             processor_addr_strobe_n;
    logic             controller_addr_strobe_n;
    logic             burst_step_n;
    logic             global_write_n;
    logic             byte_write_enable_n;
    logic [LANES-1:0] byte_lane_select_n;
    logic             chip_select_primary_n;
    logic             chip_select_high;
    logic             chip_select_third_n;
  } psa_ctl_t;

  localparam psa_ctl_t CTL_IDLE = '{
    processor_addr_strobe_n:  1'b1,
    controller_addr_strobe_n: 1'b1,
    burst_step_n:             1'b1,
    global_write_n:           1'b1,
    byte_write_enable_n:      1'b1,
    byte_lane_select_n:       4'hf,
    chip_select_primary_n:    1'b1,
    chip_select_high:         1'b0,
    chip_select_third_n:      1'b1
  };

endpackage : psa_pkg

/* File: hdl/psa_burst_ctr.sv */
`timescale 1ns/1ps
module psa_burst_ctr
  import psa_pkg::*;
(
  input  wire logic               sys_clk_in,
  input  wire logic               rst_b_in,
  input  wire logic               load_in,
  input  wire logic [BURST_W-1:0] start_in,
  input  wire logic               step_in,
  input  wire logic               mode_in,
  output logic      [BURST_W-1:0] addr_lo_out
);
  import psa_pkg::*;

  logic [BURST_W-1:0] start_r;
  logic [BURST_W-1:0] idx_r;
  logic [BURST_W-1:0] start_eff;
  logic [BURST_W-1:0] idx_nxt;

  // Wraps on its own width, so a fourth step returns to the first address
  assign start_eff = load_in ? start_in : start_r;
  assign idx_nxt   = load_in ? BURST_RST : (idx_r + {{(BURST_W-1){1'b0}}, step_in});
  assign addr_lo_out = (mode_in == MODE_LINEAR) ? (start_eff + idx_nxt)
                                                : (start_eff ^ idx_nxt);

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      start_r <= BURST_RST;
      idx_r   <= BURST_RST;
    end else begin
      start_r <= start_eff;
      idx_r   <= idx_nxt;
    end
  end

endmodule : psa_burst_ctr

/* File: hdl/psa_mem.sv */
`timescale 1ns/1ps
module psa_mem
  import psa_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  input  wire logic              sys_clk_in,
  input  wire logic [AW-1:0]     addr_in,
  input  wire logic [LANES-1:0]  lane_we_in,
  input  wire logic [WORD_W-1:0] wdata_in,
  output logic      [WORD_W-1:0] rdata_out
);
  import psa_pkg::*;

  logic [WORD_W-1:0] mem [0:(1<<AW)-1];

  assign rdata_out = mem[addr_in];

  // Unselected lanes are never touched; one process keeps a single writer on the array
  always_ff @(posedge sys_clk_in) begin
    for (int i = 0; i < LANES; i++) begin
      if (lane_we_in[i]) begin
        mem[addr_in][i*LANE_W +: LANE_W] <= wdata_in[i*LANE_W +: LANE_W];
      end
    end
  end

endmodule : psa_mem

/* File: sim/psa_host_bus.sv */
`timescale 1ns/1ps
module psa_host_bus (
  input  wire logic        sys_clk_in,
  input  wire logic        drive_in,
  input  wire logic [35:0] wdata_in,
  input  wire logic        dev_oe_in,
  input  wire logic [35:0] dev_data_in,
  output logic             oe_n_out,
  output logic [35:0]      bus_out
);
  logic [35:0] last_r = '0;
  // Outputs released in the same step as write data goes onto the shared lines
  assign oe_n_out = drive_in;
  // Undriven lines toggle, so a stale value can never pass as a match
  assign bus_out = dev_oe_in ? dev_data_in : drive_in ? wdata_in : ~last_r;
  always_ff @(posedge sys_clk_in) begin
    last_r <= bus_out;
  end
endmodule : psa_host_bus

/* File: sim/psa_sva.sv */
`timescale 1ns/1ps
module psa_sva (
  input wire logic              sys_clk_in,
  input wire logic              rst_b_in,
  input wire psa_pkg::psa_ctl_t ctl_in,
  input wire logic              data_oe_out,
  input wire logic              oe_n_in,
  input wire logic              sleep_request_in,
  input wire logic              sleep_active_out
);
  import psa_pkg::*;
  psa_ctl_t c;
  logic     sel, pst, cst, wrc, desel, rd_go, wr_go, cont;
  assign c = ctl_in;
  assign sel = !c.chip_select_primary_n && c.chip_select_high && !c.chip_select_third_n;
  assign pst = !c.processor_addr_strobe_n && !c.chip_select_primary_n;
  assign cst = !c.controller_addr_strobe_n && !pst;
  assign wrc = !c.global_write_n || (!c.byte_write_enable_n && c.byte_lane_select_n != 4'hf);
  assign desel = (pst || cst) && !sel && !sleep_request_in;
  assign rd_go = sel && !sleep_request_in && (pst || (cst && c.global_write_n
                 && c.byte_write_enable_n));
  assign wr_go = sel && cst && wrc;
  assign cont = c.processor_addr_strobe_n && c.controller_addr_strobe_n && !wrc
                && !sleep_request_in;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_oe_gated: assert property (oe_n_in |-> !data_oe_out)
    else $error("data driven with output enable high");
  a_sleep_quiet: assert property (sleep_active_out |-> !data_oe_out)
    else $error("data driven in sleep");
  a_sleep_enter: assert property (sleep_request_in [*2] |=> sleep_active_out)
    else $error("sleep not entered");
  a_wr_release: assert property (wr_go |=> !data_oe_out)
    else $error("data driven in write cycle");
  a_desel_off: assert property (desel |=> !data_oe_out)
    else $error("data driven after deselect");
  a_first_mask: assert property (desel ##1 rd_go |=> !data_oe_out)
    else $error("first read cycle not masked");
  a_read_drive: assert property (rd_go ##1 (cont && !oe_n_in) [*3] |-> data_oe_out)
    else $error("read data not driven");
  a_read_keep: assert property (data_oe_out && cont |=> oe_n_in || data_oe_out)
    else $error("read drive dropped");

  cover property (rd_go ##1 (cont && !c.burst_step_n) [*3]);
  cover property (pst ##1 wrc);
  cover property ($rose(sleep_active_out));
endmodule : psa_sva

bind psa_sram_access psa_sva psa_sva_i (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
  .ctl_in(ctl_in), .data_oe_out(data_oe_out), .oe_n_in(oe_n_in),
  .sleep_request_in(sleep_request_in), .sleep_active_out(sleep_active_out));

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import psa_pkg::*;
  localparam int AW = 8;
  logic          clk, rst_b, drv, oe_n, sleep, mode, oe, slp;
  logic [AW-1:0] addr;
  psa_ctl_t      ctl;
  logic [35:0]   wd, bus;
  logic [31:0]   dout;
  logic [3:0]    pout;
  logic [35:0]   exp_mem [256];
  int            error_cnt, cmp_count, cyc_cnt;

  psa_sram_access #(.AW(AW)) psa_sram_access_i (.sys_clk_in(clk), .rst_b_in(rst_b),
    .addr_in(addr), .ctl_in(ctl), .data_in(bus[31:0]), .parity_in(bus[35:32]),
    .data_out(dout), .parity_out(pout), .data_oe_out(oe), .oe_n_in(oe_n),
    .sleep_request_in(sleep), .burst_mode_in(mode), .sleep_active_out(slp));
  psa_host_bus psa_host_bus_i (.sys_clk_in(clk), .drive_in(drv), .wdata_in(wd),
    .dev_oe_in(oe), .dev_data_in({pout, dout}), .oe_n_out(oe_n), .bus_out(bus));

  task automatic complete_run();
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk

  function automatic psa_ctl_t on();
    psa_ctl_t c;
    c = CTL_IDLE;
    c.chip_select_primary_n = 1'b0;
    c.chip_select_high = 1'b1;
    c.chip_select_third_n = 1'b0;
    return c;
  endfunction : on

  // Deselect ends every wr and rd access, so each rd starts from a known masked cycle
  task automatic drop();
    @(negedge clk);
    ctl = CTL_IDLE;
    ctl.controller_addr_strobe_n = 1'b0;
    drv = 1'b0;
  endtask : drop

  // Fresh controller-strobe read start without waiting for its data
  task automatic go(input logic [7:0] a);
    psa_ctl_t c;
    c = on();
    c.controller_addr_strobe_n = 1'b0;
    @(negedge clk);
    ctl = c;
    addr = a;
  endtask : go

  task automatic wr(input logic p, input logic [7:0] a, input logic g, input logic b,
                    input logic [3:0] ln, input logic [35:0] w);
    psa_ctl_t c;
    c = on();
    c.controller_addr_strobe_n = 1'b0;
    if (p) begin
      c.processor_addr_strobe_n = 1'b0;
      c.global_write_n = 1'b0;
      @(negedge clk);
      ctl = c;
      addr = a;
      wd = ~w;
      drv = 1'b1;
      c = CTL_IDLE;
    end
    c.global_write_n = g;
    c.byte_write_enable_n = b;
    c.byte_lane_select_n = ln;
    @(negedge clk);
    ctl = c;
    addr = a;
    wd = w;
    drv = 1'b1;
    drop();
    for (int i = 0; i < 4; i++) begin
      if (!g || (!b && !ln[i])) begin
        exp_mem[a][8*i+:8] = w[8*i+:8];
        exp_mem[a][32+i] = w[32+i];
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input int ns);
    psa_ctl_t   c;
    int         k;
    logic [1:0] lo;
    k = 0;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      if (oe === 1'b1 && i > 0 && k <= ns) begin
        lo = mode ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k);
        chk("rdata", exp_mem[{a[7:2], lo}], {pout, dout});
        k++;
      end
      c = CTL_IDLE;
      if (i == 0) c = on();
      if (i == 0) c.controller_addr_strobe_n = 1'b0;
      else if (i <= ns) c.burst_step_n = 1'b0;
      ctl = c;
      addr = a;
    end
    chk("beats", 36'(ns + 1), 36'(k));
    drop();
  endtask : rd

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt > 2000) begin
      error_cnt++;
      complete_run();
    end
  end

  initial begin
    rst_b = 1'b0;
    ctl = CTL_IDLE;
    addr = '0;
    wd = '0;
    drv = 1'b0;
    sleep = 1'b0;
    mode = 1'b1;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    for (int a = 0; a < 8; a++) wr(0, 8'(a), 0, 0, 4'he, {4'(a), 32'h5ac3e010 + 32'(a)});
    for (int a = 0; a < 8; a++) rd(8'(a), 0);
    wr(0, 8'h02, 1, 0, 4'h5, 36'hf0f0f0f0f);
    rd(8'h02, 0);
    wr(1, 8'h05, 1, 0, 4'he, 36'h612345678);
    rd(8'h05, 0);
    wr(1, 8'h06, 0, 1, 4'hf, 36'h0abcdef01);
    rd(8'h06, 0);
    go(8'h03);
    go(8'h04);
    chk("b2b_mask", 36'h0, 36'(oe));
    @(negedge clk);
    ctl = CTL_IDLE;
    chk("b2b_oe", 36'h1, 36'(oe));
    chk("b2b_first", exp_mem[8'h03], {pout, dout});
    @(negedge clk);
    chk("b2b_second", exp_mem[8'h04], {pout, dout});
    drop();
    for (int m = 0; m < 2; m++) begin
      mode = 1'(m);
      rd(8'h01, 3);
      rd(8'h06, 3);
    end
    sleep = 1'b1;
    repeat (3) @(negedge clk);
    chk("sleep", 36'h1, 36'(slp));
    sleep = 1'b0;
    repeat (4) @(negedge clk);
    chk("wake", 36'h0, 36'(slp));
    rd(8'h05, 0);
    complete_run();
  end
endmodule : testbench
